// *** hdl/tps_sequencer.sv ***
// Purpose: Program sequencer starting voice groups on trigger key edges.
// Assumes: Triggers active low (pressed = 0), synchronous to mclk.
// Notes:   Group n starts at program word 4*n; sound play is a countdown.
`timescale 1ns/10ps
`default_nettype none
`include "tps_map.svh"

module tps_sequencer import tps_pkg::*; #(
  parameter int DEB_CYCLES = `TPS_DEB_CYCLES,
  parameter int PC_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Trigger keys, low when pressed
  input wire logic [3:0] trigInN,
  // Audio output side
  output logic audioOn,
  output logic [3:0] soundCode
);

  localparam int DEB_W = $clog2(DEB_CYCLES + 1);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  tps_state_t state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] edgeEn_r, edgeEn_nxt;
  logic [7:0] playCnt_r, playCnt_nxt;
  logic [3:0] sound_r, sound_nxt;
  logic audio_r, audio_nxt;
  logic run_r, run_nxt, runD_r;
  logic [PC_W-1:0] progAddr_r, progAddr_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [15:0] progMem [0:(1<<PC_W)-1];
  logic [15:0] instr_r;
  logic [3:0] trigDb, trigPrev_r;
  logic [7:0] rawEv, takeEv;
  logic anyEv, startPulse;
  logic [2:0] evGrp;
  tps_op_t op;

  // Debounce filter, one per trigger
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : gDeb
    logic [DEB_W-1:0] cnt_r, cnt_nxt;
    logic db_r, db_nxt;
    // Level must hold for the full time before it is accepted
    always_comb begin
      cnt_nxt = '0;
      db_nxt = db_r;
      if (trigInN[gi] != db_r) begin
        if (cnt_r == DEB_W'(DEB_CYCLES - 1)) begin
          db_nxt = trigInN[gi]; // see RULE12
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_r <= '0;
        db_r <= 1'b1;
      end else begin
        cnt_r <= cnt_nxt;
        db_r <= db_nxt;
      end
    end
    assign trigDb[gi] = db_r;
  end

  // Edge events from debounced levels
  assign rawEv = {~trigPrev_r & trigDb, trigPrev_r & ~trigDb}; // see RULE9
  assign takeEv = rawEv & edgeEn_r & {8{run_r}}; // see RULE1, see RULE2
  assign anyEv = |takeEv;
  assign startPulse = run_r & ~runD_r;
  assign op = tps_op_t'(instr_r[`TPS_OP_MSB:`TPS_OP_LSB]);

  // Entry group of an edge equals its enable bit index
  always_comb begin
    evGrp = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (takeEv[i]) begin
        evGrp = 3'(i); // see RULE3
      end
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    edgeEn_nxt = edgeEn_r;
    playCnt_nxt = playCnt_r;
    sound_nxt = sound_r;
    if (regWrite && regAddr == `TPS_REG_EDGE_EN) begin
      edgeEn_nxt = regWrData[7:0];
    end
    if (!run_r) begin
      state_nxt = ST_IDLE;
    end else if (anyEv) begin
      // Abort whatever runs and enter the edge's group
      state_nxt = ST_FETCH; // see RULE10
      pc_nxt = {3'h0, evGrp, 2'b00}; // see RULE6
    end else if (startPulse) begin
      state_nxt = ST_FETCH;
      pc_nxt = {`TPS_PWRON_GROUP, 2'b00};
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_FETCH: begin
          state_nxt = ST_EXEC;
        end
        ST_EXEC: begin
          case (op)
            OP_END: begin
              state_nxt = ST_IDLE; // see RULE11
            end
            OP_LDEN: begin
              edgeEn_nxt = instr_r[7:0]; // see RULE8
              pc_nxt = pc_r + 1'b1;
              state_nxt = ST_FETCH;
            end
            OP_JP: begin
              pc_nxt = {instr_r[`TPS_GRP_MSB:0], 2'b00}; // see RULE4
              state_nxt = ST_FETCH;
            end
            OP_JPC: begin
              if (trigDb[instr_r[`TPS_COND_TRIG_MSB:`TPS_COND_TRIG_LSB]]
                  == instr_r[`TPS_COND_LEVEL_BIT]) begin
                pc_nxt = {instr_r[`TPS_GRP_MSB:0], 2'b00}; // see RULE5
              end else begin
                pc_nxt = pc_r + 1'b1;
              end
              state_nxt = ST_FETCH;
            end
            OP_PLAY: begin
              sound_nxt = instr_r[`TPS_SOUND_MSB:`TPS_SOUND_LSB];
              playCnt_nxt = instr_r[`TPS_LEN_MSB:0];
              state_nxt = ST_PLAY;
            end
            default: begin
              pc_nxt = pc_r + 1'b1;
              state_nxt = ST_FETCH;
            end
          endcase
        end
        ST_PLAY: begin
          // Sound runs until its count expires
          if (playCnt_r <= 8'h01) begin
            pc_nxt = pc_r + 1'b1;
            state_nxt = ST_FETCH;
          end else begin
            playCnt_nxt = playCnt_r - 1'b1; // see RULE7
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    audio_nxt = (state_nxt == ST_PLAY);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      pc_r <= '0;
      edgeEn_r <= `TPS_EDGE_EN_RST;
      playCnt_r <= 8'h00;
      sound_r <= 4'h0;
      audio_r <= 1'b0;
      trigPrev_r <= 4'hF;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      edgeEn_r <= edgeEn_nxt;
      playCnt_r <= playCnt_nxt;
      sound_r <= sound_nxt;
      audio_r <= audio_nxt;
      trigPrev_r <= trigDb;
    end
  end

  // Register port decode
  always_comb begin
    run_nxt = run_r;
    progAddr_nxt = progAddr_r;
    rdData_nxt = 32'h00000000;
    if (regWrite) begin
      case (regAddr)
        `TPS_REG_CTRL: run_nxt = regWrData[`TPS_CTRL_RUN_BIT];
        `TPS_REG_PROG_ADDR: progAddr_nxt = regWrData[PC_W-1:0];
        `TPS_REG_PROG_DATA: progAddr_nxt = progAddr_r + 1'b1;
        default: run_nxt = run_r;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `TPS_REG_CTRL: rdData_nxt = {31'h0, run_r};
        `TPS_REG_EDGE_EN: rdData_nxt = {24'h0, edgeEn_r};
        `TPS_REG_STATUS: rdData_nxt = {16'h0, pc_r, trigDb, state_r};
        `TPS_REG_PROG_ADDR: rdData_nxt = {24'h0, progAddr_r};
        default: rdData_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      runD_r <= 1'b0;
      progAddr_r <= '0;
      rdData_r <= 32'h00000000;
    end else begin
      run_r <= run_nxt;
      runD_r <= run_r;
      progAddr_r <= progAddr_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // Program store, written over the port, read every cycle
  always_ff @(posedge mclk) begin
    if (regWrite && regAddr == `TPS_REG_PROG_DATA) begin
      progMem[progAddr_r] <= regWrData[15:0];
    end
    instr_r <= progMem[pc_r];
  end

  assign regRdData = rdData_r;
  assign audioOn = audio_r;
  assign soundCode = sound_r;

  // Checks
  a_fall_one_start: assert property ( // see RULE6
    run_r && edgeEn_r == 8'h01 && rawEv[0]
    |=> pc_r == '0 && state_r == ST_FETCH)
    else $error("falling edge of trigger one did not restart group 0");
  a_others_ignored: assert property ( // see RULE1
    run_r && edgeEn_r == 8'h01 && !rawEv[0] && state_r == ST_PLAY
    && playCnt_r > 8'h01 |=> state_r == ST_PLAY)
    else $error("disabled edge disturbed playback");
  a_release_entry: assert property ( // see RULE3
    run_r && edgeEn_r == 8'h11 && rawEv[4]
    |=> pc_r == PC_W'(16) ##1 state_r == ST_EXEC)
    else $error("release of trigger one did not enter group 4");
  a_both_edges: assert property ( // see RULE2
    run_r && edgeEn_r == 8'h11 && (rawEv[0] || rawEv[4])
    |=> state_r == ST_FETCH)
    else $error("enabled edge of trigger one ignored");
  a_loop_group0: assert property ( // see RULE4
    state_r == ST_EXEC && op == OP_JP && instr_r[`TPS_GRP_MSB:0] == 6'h00
    && !anyEv && run_r |=> pc_r == '0 && state_r == ST_FETCH
    ##1 (state_r == ST_EXEC || $past(anyEv)))
    else $error("jump to group 0 did not restart it");
  a_cond_taken: assert property ( // see RULE5
    state_r == ST_EXEC && op == OP_JPC && instr_r[10:8] == 3'b000
    && !anyEv && run_r
    |-> if (trigDb[0]) (##1 pc_r == $past(pc_r) + 1'b1)
        else (##1 pc_r == {$past(instr_r[5:0]), 2'b00}))
    else $error("conditional jump on trigger one low went wrong");
  a_none_enabled: assert property ( // see RULE7
    run_r && edgeEn_r == 8'h00 && state_r == ST_PLAY && playCnt_r > 8'h02
    |=> (audioOn && $stable(soundCode)) [*2])
    else $error("playback broke with all edges disabled");
  a_load_now: assert property ( // see RULE8
    state_r == ST_EXEC && op == OP_LDEN && run_r && !anyEv
    && !(regWrite && regAddr == `TPS_REG_EDGE_EN)
    |=> edgeEn_r == $past(instr_r[7:0]))
    else $error("edge enable load not applied at once");
  a_abort_now: assert property ( // see RULE10
    anyEv |=> state_r == ST_FETCH && !audioOn && pc_r[1:0] == 2'b00)
    else $error("enabled edge did not abort at once");
  a_end_halts: assert property ( // see RULE11
    state_r == ST_EXEC && op == OP_END && !anyEv
    |=> state_r == ST_IDLE && !audioOn)
    else $error("end did not halt");
  a_debounce_hold: assert property ( // see RULE12
    $changed(trigDb[0]) |-> $past(gDeb[0].cnt_r) == DEB_W'(DEB_CYCLES - 1))
    else $error("trigger level accepted before debounce time");
  a_rise_entry: assert property ( // see RULE9
    takeEv[7:4] != 4'h0 && takeEv[3:0] == 4'h0
    |=> pc_r >= PC_W'(16) && pc_r <= PC_W'(28))
    else $error("rising edge did not enter groups 4 to 7");
  a_fall_entry: assert property ( // see RULE9
    takeEv[3:0] != 4'h0 |=> pc_r <= PC_W'(12))
    else $error("falling edge did not enter groups 0 to 3");

  // Main scenarios reached
  c_play_done: cover property (state_r == ST_PLAY ##1 state_r == ST_FETCH);
  c_abort_play: cover property (state_r == ST_PLAY && anyEv);
  c_cond_jump: cover property (state_r == ST_EXEC && op == OP_JPC);
  c_end_seen: cover property (state_r == ST_EXEC && op == OP_END);
  c_rise_entry: cover property (takeEv[4]);

endmodule : tps_sequencer
`default_nettype wire

// *** hdl/tps_map.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
//          for the trigger playback sequencer.
// Assumes: 20 MHz mclk, 32-bit plain register port, 16-bit program words.
// Notes:   Rules of the block follow.
// Contract
// RULE1: Enable value 0x01 reacts only to trigger one falling edge.
// RULE2: Enable value 0x11 reacts to both edges of trigger one.
// RULE3: Enabled trigger one release aborts playback, starts group entry 4.
// RULE4: Jump back to group 0 loops playback until an enabled edge.
// RULE5: Jump on trigger one low taken only when pressed, else next word.
// RULE6: With 0x01 a new press restarts group 0 from its start.
// RULE7: Enable value 0x00 ignores all presses; current playback continues.
// RULE8: Any later enable load takes effect at once.
// RULE9: Enable bits 7..4 rising edges four..one, bits 3..0 falling edges.
// RULE10: Enabled edge stops current group at once, starts its entry group.
// RULE11: End halts all activity at once; idle until an enabled edge.
// RULE12: Edges and jump conditions use debounced trigger levels.
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

// Register byte offsets
`define TPS_REG_CTRL 8'h00
`define TPS_REG_EDGE_EN 8'h04
`define TPS_REG_STATUS 8'h08
`define TPS_REG_PROG_ADDR 8'h0C
`define TPS_REG_PROG_DATA 8'h10

// Control fields and reset values
`define TPS_CTRL_RUN_BIT 0
`define TPS_EDGE_EN_RST 8'h00
`define TPS_PWRON_GROUP 6'h20

// Instruction word fields
`define TPS_OP_MSB 15
`define TPS_OP_LSB 12
`define TPS_GRP_MSB 5
`define TPS_COND_TRIG_MSB 9
`define TPS_COND_TRIG_LSB 8
`define TPS_COND_LEVEL_BIT 10
`define TPS_SOUND_MSB 11
`define TPS_SOUND_LSB 8
`define TPS_LEN_MSB 7

// Timing
`define TPS_MCLK_MHZ 20
`define TPS_DEB_TIME_US 45000
`define TPS_DEB_CYCLES (`TPS_DEB_TIME_US * `TPS_MCLK_MHZ)

`endif

// *** hdl/tps_pkg.sv ***
// Purpose: Types shared by the trigger playback sequencer.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   States are one-hot.
package tps_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_PLAY = 4'b1000
  } tps_state_t;

  // Instruction opcodes
  typedef enum logic [3:0] {
    OP_END = 4'h0,
    OP_LDEN = 4'h1,
    OP_JP = 4'h2,
    OP_JPC = 4'h3,
    OP_PLAY = 4'h4
  } tps_op_t;

endpackage : tps_pkg

// *** test/tps_keys.sv ***
// Purpose: Push-button keys on the four trigger pins.
// Assumes: A held key pulls its pin low; pull-ups keep free pins high.
// Notes:   Contacts bounce back once, for one cycle, two cycles after every change.
`timescale 1ns/10ps
`default_nettype none

module tps_keys (
  // Clock
  input wire logic mclk,
  // Key state from the bench, high while held
  input wire logic [3:0] press,
  // Trigger pins, low while held
  output logic [3:0] trigInN
);
  logic [3:0] last_r = 4'h0;
  logic [3:0] moved_r = 4'h0;
  logic [1:0] chatter_r = 2'h0;

  // Track key changes and time the chatter
  always @(posedge mclk) begin
    if (press != last_r) begin
      chatter_r <= 2'h2;
      moved_r <= press ^ last_r;
    end else if (chatter_r != 2'h0) begin
      chatter_r <= chatter_r - 2'h1;
    end
    last_r <= press;
  end

  // Changed contacts flip back for one cycle
  assign trigInN = ~press ^ (chatter_r[0] ? moved_r : 4'h0);
endmodule : tps_keys
`default_nettype wire

// *** test/tb_trigger_playback_sequencer.sv ***
// Purpose: Self-checking bench for the trigger playback sequencer.
// Assumes: Debounce shortened to 4 cycles; keys modelled by tps_keys.
// Notes:   Programs load over the register port; the last three scenarios reload group 0.
`timescale 1ns/10ps
`default_nettype none
`include "tps_map.svh"

module tb_trigger_playback_sequencer;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic [31:0] regRdData;
  logic [3:0] press = 4'h0;
  logic [3:0] trigInN;
  logic audioOn;
  logic [3:0] soundCode;
  int numErrors = 0;
  int checkCount = 0;

  // Clock, design and keys
  always #25 mclk = ~mclk;
  tps_sequencer #(.DEB_CYCLES(4)) dut (.mclk(mclk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .trigInN(trigInN),
    .audioOn(audioOn), .soundCode(soundCode));
  tps_keys keys (.mclk(mclk), .press(press), .trigInN(trigInN));

  // Verdict and end of run
  task automatic completeRun();
    if (numErrors == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : completeRun

  // Compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    cyc(1);
    regWrite <= 1'h0;
    cyc(1);
  endtask : wr

  // Register read; data stand one cycle, then zero
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFFFFFF);
    regAddr <= a;
    regRead <= 1'h1;
    cyc(1);
    regRead <= 1'h0;
    cyc(1);
    chk(regRdData & m, exp);
    cyc(1);
    chk(regRdData, 32'h0);
  endtask : rd

  // Load one group of four words, first word in the top bits
  task automatic grp(input logic [7:0] g, input logic [63:0] w);
    wr(`TPS_REG_PROG_ADDR, {24'h0, g << 2});
    for (int i = 3; i >= 0; i--)
      wr(`TPS_REG_PROG_DATA, {16'h0, w[i*16 +: 16]});
  endtask : grp

  // Bounded wait for a sound to play
  task automatic waitSnd(input logic [3:0] s);
    int n = 0;
    while ((audioOn !== 1'h1 || soundCode !== s) && n < 200) begin
      cyc(1);
      n++;
    end
    chk({27'h0, audioOn, soundCode}, {27'h0, 1'h1, s});
  endtask : waitSnd

  // Bounded wait for silence, then expect the idle state
  task automatic waitIdle();
    int n = 0;
    while (audioOn !== 1'h0 && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(6);
    rd(`TPS_REG_STATUS, 32'h1, 32'hF);
  endtask : waitIdle

  // Scenarios
  initial begin
    cyc(4);
    rst <= 1'h0;
    cyc(1);
    rd(`TPS_REG_EDGE_EN, 32'h0);
    rd(`TPS_REG_STATUS, 32'hF1, 32'hFF);
    rd(8'h40, 32'h0);
    wr(`TPS_REG_EDGE_EN, 32'h5A);
    rd(`TPS_REG_EDGE_EN, 32'h5A);
    grp(8'h20, 64'h1001_0000_0000_0000);
    grp(8'h00, 64'h1011_4114_2000_0000);
    grp(8'h04, 64'h4504_0000_0000_0000);
    wr(`TPS_REG_CTRL, 32'h1);
    cyc(10);
    rd(`TPS_REG_EDGE_EN, 32'h01);
    // Other keys ignored with only the first falling edge on
    press <= 4'h2;
    cyc(20);
    rd(`TPS_REG_STATUS, 32'hD1, 32'hFF);
    press <= 4'h0;
    cyc(20);
    rd(`TPS_REG_STATUS, 32'hF1, 32'hFF);
    // Level hold: loops while held, release starts entry 4
    press <= 4'h1;
    waitSnd(4'h1);
    rd(`TPS_REG_EDGE_EN, 32'h11);
    cyc(60);
    waitSnd(4'h1);
    press <= 4'h0;
    waitSnd(4'h5);
    waitIdle();
    // Second press restarts the long sound
    grp(8'h00, 64'h1001_4140_0000_0000);
    press <= 4'h1;
    waitSnd(4'h1);
    press <= 4'h0;
    cyc(20);
    press <= 4'h1;
    cyc(55);
    chk({31'h0, audioOn}, 32'h1);
    waitIdle();
    // All edges off, then both edges back after playback
    grp(8'h00, 64'h1000_4140_1011_0000);
    press <= 4'h0;
    cyc(12);
    press <= 4'h1;
    waitSnd(4'h1);
    press <= 4'h0;
    cyc(20);
    press <= 4'h1;
    cyc(30);
    rd(`TPS_REG_EDGE_EN, 32'h0);
    cyc(25);
    chk({31'h0, audioOn}, 32'h0);
    rd(`TPS_REG_EDGE_EN, 32'h11);
    press <= 4'h0;
    waitSnd(4'h5);
    waitIdle();
    // Conditional jump repeats only while the key is held
    grp(8'h00, 64'h1001_4108_3000_0000);
    press <= 4'h1;
    waitSnd(4'h1);
    cyc(40);
    waitSnd(4'h1);
    press <= 4'h0;
    cyc(30);
    waitIdle();
    chk({28'h0, soundCode}, 32'h1);
    completeRun();
  end

  // Watchdog against a hang
  initial begin
    #2_000_000;
    numErrors++;
    completeRun();
  end
endmodule : tb_trigger_playback_sequencer
`default_nettype wire
